//--- testbench/mode_ctrl_model.sv
// Memory controller model issuing mode register reads and writes
`timescale 1ns/100ps
module mode_ctrl_model (
    input  wire logic                        ref_clk, // Command clock
    output mode_regs_pkg::mode_cmd_type      cmd,     // Command out
    input  wire mode_regs_pkg::mode_rsp_type rsp      // Read answer
);
    import mode_regs_pkg::*;
    initial cmd = '0;
    // One command held a full cycle; read data taken one cycle later
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [7:0] data, output logic [7:0] rd);
        @(negedge ref_clk);
        cmd = '{wrEn: wr, rdEn: !wr, addr: addr, data: data};
        @(negedge ref_clk);
        // Idle lines show the inverse so no stale value looks valid
        cmd = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~addr, data: ~data};
        rd = (!wr && rsp.valid === 1'b1) ? rsp.data : 8'hxx;
    endtask
endmodule

//--- testbench/sdram_mode_regs_assertions.sv
// Checker: port assertions for the mode register bank
`timescale 1ns/100ps
module sdram_mode_regs_assertions #(
    parameter logic [1:0] DEV_TYPE = 2'h0, // Type code
    parameter logic [3:0] DENSITY  = 4'h0, // Density code
    parameter logic [1:0] IO_WIDTH = 2'h0  // Width code
) (
    input wire logic                        ref_clk,           // Clock
    input wire logic                        srst,              // Reset
    input wire mode_regs_pkg::mode_cmd_type cmd,               // Command
    input wire logic [2:0]                  rateIn,            // Sensor
    input wire mode_regs_pkg::mode_rsp_type rsp,               // Answer
    input wire logic [3:0]                  driveStrengthCode, // Drive
    input wire logic                        overTemp,          // Hot
    input wire logic                        derate,            // Derate
    input wire logic                        outOfRange,        // Limit
    input wire mode_regs_pkg::cal_req_type  calReq,            // Cal
    input wire logic [7:0]                  testMode           // Test
);
    import mode_regs_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    function automatic cal_kind_type kindOf(logic [7:0] c);
        case (c)
            CAL_INIT:  return CAL_INIT_K;
            CAL_LONG:  return CAL_LONG_K;
            CAL_SHORT: return CAL_SHORT_K;
            CAL_RESET: return CAL_RESET_K;
            default:   return CAL_NONE_K;
        endcase
    endfunction
    logic dsWr;
    logic calWr;
    assign dsWr = cmd.wrEn && cmd.addr == ADDR_IO_DRIVE && cmd.data[3:0]
        inside {DS_34R3, DS_40R, DS_48R, DS_60R, DS_80R, DS_120R};
    assign calWr = cmd.wrEn && cmd.addr == ADDR_CAL_CODE
        && DEV_TYPE == TYPE_PREFETCH4 && kindOf(cmd.data) != CAL_NONE_K;
    sequence rdAt(logic [7:0] a);
        cmd.rdEn && cmd.addr == a;
    endsequence
    sequence wrAt(logic [7:0] a);
        cmd.wrEn && cmd.addr == a;
    endsequence
    read_answer_a: assert property (cmd.rdEn |=> rsp.valid)
        else $error("read gave no answer");
    answer_cause_a: assert property (rsp.valid |-> $past(cmd.rdEn))
        else $error("answer without a read");
    temp_reserved_a: assert property (rdAt(ADDR_TEMP) |=>
        rsp.data[6:3] == 4'h0) else $error("temperature spare bits set");
    geometry_read_a: assert property (rdAt(ADDR_GEOMETRY) |=>
        rsp.data == {IO_WIDTH, DENSITY, DEV_TYPE})
        else $error("geometry word wrong");
    drive_update_a: assert property (dsWr |=>
        driveStrengthCode == $past(cmd.data[3:0]))
        else $error("drive code not taken");
    drive_hold_a: assert property (!dsWr |=> $stable(driveStrengthCode))
        else $error("drive code changed");
    cal_pulse_a: assert property (calWr |=>
        calReq.req && calReq.kind == kindOf($past(cmd.data)))
        else $error("calibration pulse wrong");
    cal_cause_a: assert property (calReq.req |-> $past(calWr))
        else $error("calibration pulse without legal write");
    test_write_a: assert property (wrAt(ADDR_TEST_MODE) |=>
        testMode == $past(cmd.data)) else $error("test byte not taken");
    derate_hot_a: assert property (derate |-> overTemp && !outOfRange)
        else $error("derate without hot state");
endmodule

bind sdram_mode_regs sdram_mode_regs_assertions #(
    .DEV_TYPE(DEV_TYPE), .DENSITY(DENSITY), .IO_WIDTH(IO_WIDTH)
) chk (.ref_clk(ref_clk), .srst(srst), .cmd(cmd), .rateIn(rateIn),
    .rsp(rsp), .driveStrengthCode(driveStrengthCode), .overTemp(overTemp),
    .derate(derate), .outOfRange(outOfRange), .calReq(calReq),
    .testMode(testMode));

//--- testbench/sdram_mode_regs_tb.sv
// Self-checking bench for the mode register bank
`timescale 1ns/100ps
module sdram_mode_regs_tb;
    import mode_regs_pkg::*;
    localparam logic [7:0] VID  = 8'h3C; // Arbitrary value
    localparam logic [7:0] DREV = 8'hC5; // Arbitrary value
    localparam logic [7:0] GEO  = {WIDTH_X16, DENSITY_MAX, TYPE_PREFETCH4};
    typedef struct {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } row_type;
    logic         ref_clk;
    logic         srst;
    logic   [2:0] rateIn;
    logic   [3:0] driveStrengthCode;
    logic   [7:0] testMode;
    logic   [7:0] rd;
    logic         overTemp;
    logic         derate;
    logic         outOfRange;
    mode_cmd_type cmd;
    mode_rsp_type rsp;
    cal_req_type  calReq;
    int           errorCnt = 0;
    int           comparisons = 0;
    row_type rows [14] = '{
        '{1'b0, ADDR_TEMP, 8'h00, 8'h03}, '{1'b0, ADDR_VENDOR, 8'h00, VID},
        '{1'b0, ADDR_DIE_REV, 8'h00, DREV},
        '{1'b0, ADDR_SECOND_REV, 8'h00, 8'h00},
        '{1'b0, ADDR_GEOMETRY, 8'h00, GEO}, '{1'b1, ADDR_VENDOR, 8'hFF, 8'h00},
        '{1'b0, ADDR_VENDOR, 8'h00, VID}, '{1'b1, ADDR_GEOMETRY, 8'h9B, 8'h00},
        '{1'b0, ADDR_GEOMETRY, 8'h00, GEO},
        '{1'b1, ADDR_TEST_MODE, 8'hA5, 8'h00},
        '{1'b0, ADDR_TEST_MODE, 8'h00, 8'hA5},
        '{1'b0, ADDR_IO_DRIVE, 8'h00, 8'h00},
        '{1'b0, ADDR_CAL_CODE, 8'h00, 8'h00}, '{1'b0, 8'h0B, 8'h00, 8'h00}
    };
    logic [7:0] calCodes [6] = '{CAL_INIT, CAL_LONG, CAL_SHORT, CAL_RESET,
                                 8'h00, 8'h57};

    sdram_mode_regs #(
        .VENDOR_ID(VID), .DIE_REV(DREV), .DENSITY(DENSITY_MAX),
        .IO_WIDTH(WIDTH_X16), .DEV_TYPE(TYPE_PREFETCH4)
    ) DUT (
        .ref_clk(ref_clk), .srst(srst), .cmd(cmd), .rateIn(rateIn),
        .rsp(rsp), .driveStrengthCode(driveStrengthCode),
        .overTemp(overTemp), .derate(derate), .outOfRange(outOfRange),
        .calReq(calReq), .testMode(testMode)
    );
    mode_ctrl_model ctrl (.ref_clk(ref_clk), .cmd(cmd), .rsp(rsp));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("FAIL time %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic endSim;
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Whole run is about 160 cycles; this allows over thirty times that
    initial begin
        #20000;
        errorCnt++;
        endSim;
    end
    initial begin
        logic [3:0] dsExp;
        srst = 1'b1;
        rateIn = RATE_X1;
        cycles(8);
        srst = 1'b0;
        foreach (rows[i]) begin
            ctrl.access(rows[i].wr, rows[i].addr, rows[i].data, rd);
            if (!rows[i].wr)
                check(rd, rows[i].exp);
        end
        dsExp = DS_RESET;
        check({4'h0, driveStrengthCode}, {4'h0, dsExp});
        for (int c = 0; c < 16; c++) begin
            ctrl.access(1'b1, ADDR_IO_DRIVE, {4'hF, 4'(c)}, rd);
            if (4'(c) inside {DS_34R3, DS_40R, DS_48R, DS_60R,
                              DS_80R, DS_120R})
                dsExp = 4'(c);
            check({4'h0, driveStrengthCode}, {4'h0, dsExp});
        end
        foreach (calCodes[i]) begin
            ctrl.access(1'b1, ADDR_CAL_CODE, calCodes[i], rd);
            check({7'h0, calReq.req}, {7'h0, i < 4});
            if (i < 4)
                check({5'h0, calReq.kind}, 8'(i + 1));
            else
                check({5'h0, calReq.kind}, {5'h0, CAL_NONE_K});
        end
        for (int r = 0; r < 8; r++) begin
            rateIn = 3'(r);
            cycles(6);
            check({5'h0, overTemp, derate, outOfRange},
                  {5'h0, rateIn[2], rateIn == RATE_QTR_DERATE,
                   rateIn == RATE_LOW_LIMIT || rateIn == RATE_HIGH_LIMIT});
        end
        ctrl.access(1'b0, ADDR_TEMP, 8'h00, rd);
        check(rd, 8'h87);
        ctrl.access(1'b0, ADDR_TEMP, 8'h00, rd);
        check(rd, 8'h07);
        rateIn = RATE_X1;
        cycles(6);
        rateIn = RATE_HIGH_LIMIT;
        cycles(6);
        ctrl.access(1'b0, ADDR_TEMP, 8'h00, rd);
        check(rd, 8'h87);
        rateIn = RATE_X1;
        ctrl.access(1'b1, ADDR_IO_DRIVE, {4'h0, DS_120R}, rd);
        cycles(6);
        srst = 1'b1;
        cycles(2);
        srst = 1'b0;
        check(testMode, 8'h00);
        check({4'h0, driveStrengthCode}, {4'h0, DS_RESET});
        ctrl.access(1'b0, ADDR_TEMP, 8'h00, rd);
        check(rd, 8'h03);
        endSim;
    end
endmodule

//--- verilog/mode_regs_pkg.sv
// Package: mode register addresses, field layouts, codes and carrier types
package mode_regs_pkg;

    // ------------------------------------------------------------
    // Mode register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_IO_DRIVE   = 8'h03;
    localparam logic [7:0] ADDR_TEMP       = 8'h04;
    localparam logic [7:0] ADDR_VENDOR     = 8'h05;
    localparam logic [7:0] ADDR_DIE_REV    = 8'h06;
    localparam logic [7:0] ADDR_SECOND_REV = 8'h07;
    localparam logic [7:0] ADDR_GEOMETRY   = 8'h08;
    localparam logic [7:0] ADDR_TEST_MODE  = 8'h09;
    localparam logic [7:0] ADDR_CAL_CODE   = 8'h0A;

    // ------------------------------------------------------------
    // Drive strength codes (bits [3:0] of io_drive_config)
    // ------------------------------------------------------------
    localparam logic [3:0] DS_34R3 = 4'h1;
    localparam logic [3:0] DS_40R  = 4'h2;
    localparam logic [3:0] DS_48R  = 4'h3;
    localparam logic [3:0] DS_60R  = 4'h4;
    localparam logic [3:0] DS_80R  = 4'h6;
    localparam logic [3:0] DS_120R = 4'h7;
    localparam logic [3:0] DS_RESET = DS_40R;

    // ------------------------------------------------------------
    // Refresh-rate report codes (bits [2:0] of device_temperature)
    // ------------------------------------------------------------
    localparam logic [2:0] RATE_LOW_LIMIT  = 3'h0;
    localparam logic [2:0] RATE_X4         = 3'h1;
    localparam logic [2:0] RATE_X2         = 3'h2;
    localparam logic [2:0] RATE_X1         = 3'h3;
    localparam logic [2:0] RATE_RESERVED   = 3'h4;
    localparam logic [2:0] RATE_QTR        = 3'h5;
    localparam logic [2:0] RATE_QTR_DERATE = 3'h6;
    localparam logic [2:0] RATE_HIGH_LIMIT = 3'h7;
    localparam int         HOT_BIT         = 2;
    localparam int         FLAG_BIT        = 7;

    // ------------------------------------------------------------
    // Geometry field codes
    // ------------------------------------------------------------
    localparam logic [1:0] TYPE_PREFETCH4 = 2'h0;
    localparam logic [1:0] TYPE_PREFETCH2 = 2'h1;
    localparam logic [3:0] DENSITY_MAX    = 4'h9;
    localparam logic [1:0] WIDTH_X32      = 2'h0;
    localparam logic [1:0] WIDTH_X16      = 2'h1;
    localparam logic [1:0] WIDTH_X8       = 2'h2;

    // ------------------------------------------------------------
    // Calibration codes
    // ------------------------------------------------------------
    localparam logic [7:0] CAL_INIT  = 8'hFF;
    localparam logic [7:0] CAL_LONG  = 8'hAB;
    localparam logic [7:0] CAL_SHORT = 8'h56;
    localparam logic [7:0] CAL_RESET = 8'hC3;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CAL_NONE_K  = 3'b000,
        CAL_INIT_K  = 3'b001,
        CAL_LONG_K  = 3'b010,
        CAL_SHORT_K = 3'b011,
        CAL_RESET_K = 3'b100
    } cal_kind_type;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] data;
    } mode_cmd_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } mode_rsp_type;

    typedef struct packed {
        logic [1:0] ioWidth;
        logic [3:0] density;
        logic [1:0] sdramType;
    } geometry_type;

    typedef struct packed {
        logic         req;
        cal_kind_type kind;
    } cal_req_type;

endpackage

//--- verilog/sdram_mode_regs.sv
// Mode register bank, addresses 03h to 0Ah, of a low-power DDR SDRAM
//
// How it works
// R1 - Drive-strength code 1,2,3,4,6,7 selects 34.3..120 ohm; others ignored.
// R2 - Register 03h holds drive code in [3:0]; [7:4] reserved.
// R3 - Register 04h read-only: flag bit 7, rate report bits [2:0].
// R4 - Rate report codes 000b..111b give refresh multiplier or limits.
// R5 - Reading register 04h clears the update flag.
// R6 - Update flag is zero after power-up.
// R7 - Flag sets when rate report changes, stays until read.
// R8 - Rate report bit 2 set means above 85 degrees Celsius.
// R9 - Controller lengthens core timings by 1.875 ns on derating.
// R10 - Controller treats 000b and 111b as out of range.
// R11 - Register 05h returns read-only vendor code.
// R12 - Register 06h returns read-only die revision.
// R13 - Register 07h returns read-only fixed second revision.
// R14 - Register 08h: type [1:0], density [5:2], width [7:6].
// R15 - Type 00b/01b prefetch; density 0000b..1001b from 64Mb.
// R16 - Width 00b x32, 01b x16, 10b x8.
// R17 - Register 09h is vendor test mode, all bits vendor-defined.
// R18 - Register 0Ah accepts 8-bit calibration code; code accepts it only on 4n-prefetch parts.
// R19 - Calibration codes FF, AB, 56, C3; others reserved.
// R20 - Reserved calibration codes raise no calibration request.
// R21 - Reserved bits read zero; read-only writes change nothing.
`timescale 1ns/100ps
module sdram_mode_regs #(
    parameter logic [7:0] VENDOR_ID  = 8'hA5,   // Arbitrary value
    parameter logic [7:0] DIE_REV    = 8'h5A,   // Arbitrary value
    parameter logic [7:0] SECOND_REV = 8'h00,   // Fixed default
    parameter logic [1:0] DEV_TYPE   = 2'h0,    // Prefetch type
    parameter logic [3:0] DENSITY    = 4'h6,    // Density code
    parameter logic [1:0] IO_WIDTH   = 2'h0     // Width code
) (
    input  wire logic                       ref_clk,   // Command clock
    input  wire logic                       srst,      // Sync reset, high
    input  wire mode_regs_pkg::mode_cmd_type cmd,      // Read/write command
    input  wire logic [2:0]                 rateIn,    // Sensor rate, async
    output mode_regs_pkg::mode_rsp_type     rsp,       // Read answer
    output logic [3:0]                      driveStrengthCode, // Drive code
    output logic                            overTemp,  // Above 85 C
    output logic                            derate,    // Timing derate
    output logic                            outOfRange, // Limit exceeded
    output mode_regs_pkg::cal_req_type      calReq,    // Cal pulse
    output logic [7:0]                      testMode   // Test mode bits
);
    import mode_regs_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic isDriveLegal(input logic [3:0] code);
        // R1 legal drive codes
        isDriveLegal = (code == DS_34R3) || (code == DS_40R) ||
                       (code == DS_48R)  || (code == DS_60R) ||
                       (code == DS_80R)  || (code == DS_120R);
    endfunction

    function automatic cal_kind_type calDecode(input logic [7:0] code);
        // R19 calibration code decode
        unique case (code)
            CAL_INIT:  calDecode = CAL_INIT_K;
            CAL_LONG:  calDecode = CAL_LONG_K;
            CAL_SHORT: calDecode = CAL_SHORT_K;
            CAL_RESET: calDecode = CAL_RESET_K;
            default:   calDecode = CAL_NONE_K;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic         wrDrive;
    logic         wrTest;
    logic         wrCal;
    logic         rdTemp;
    cal_kind_type calKind;
    logic [2:0]   rate;
    logic         updateFlag;
    geometry_type geom;
    logic [7:0]   tempByte;
    logic [7:0]   readData;
    logic [3:0]   drive_r;
    logic [7:0]   testMode_r;
    cal_req_type  cal_r;
    mode_rsp_type rsp_r;

    // R2 drive register address
    assign wrDrive = cmd.wrEn && (cmd.addr == ADDR_IO_DRIVE) &&
                     isDriveLegal(cmd.data[3:0]);
    // R17 test mode register
    assign wrTest  = cmd.wrEn && (cmd.addr == ADDR_TEST_MODE);
    // R18 calibration register, 4n-prefetch parts only
    assign wrCal   = cmd.wrEn && (cmd.addr == ADDR_CAL_CODE) &&
                     (DEV_TYPE == TYPE_PREFETCH4);
    // R5 temperature read
    assign rdTemp  = cmd.rdEn && (cmd.addr == ADDR_TEMP);
    assign calKind = calDecode(cmd.data);

    // ------------------------------------------------------------
    // Temperature tracking
    // ------------------------------------------------------------
    temp_flag_tracker tracker (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .rateIn     (rateIn),
        .flagClear  (rdTemp),
        .rate       (rate),
        .updateFlag (updateFlag)
    );

    // R3 temperature register layout
    assign tempByte = {updateFlag, 4'h0, rate};

    // R14 geometry layout
    // R15 type and density codes
    // R16 width codes
    assign geom = '{ioWidth: IO_WIDTH, density: DENSITY,
                    sdramType: DEV_TYPE};

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // R21 write-only and unmapped read zero
    always_comb begin
        unique case (cmd.addr)
            ADDR_TEMP:       readData = tempByte;
            // R11 vendor code
            ADDR_VENDOR:     readData = VENDOR_ID;
            // R12 die revision
            ADDR_DIE_REV:    readData = DIE_REV;
            // R13 second revision
            ADDR_SECOND_REV: readData = SECOND_REV;
            ADDR_GEOMETRY:   readData = geom;
            ADDR_TEST_MODE:  readData = testMode_r;
            default:         readData = ZERO_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // R1 store only legal codes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            drive_r <= DS_RESET;
        end else if (wrDrive) begin
            drive_r <= cmd.data[3:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            testMode_r <= ZERO_BYTE;
        end else if (wrTest) begin
            testMode_r <= cmd.data;
        end
    end

    // R20 reserved codes give no pulse
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cal_r <= '{req: 1'b0, kind: CAL_NONE_K};
        end else begin
            cal_r.req  <= wrCal && (calKind != CAL_NONE_K);
            cal_r.kind <= wrCal ? calKind : cal_r.kind;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rsp_r <= '{valid: 1'b0, data: ZERO_BYTE};
        end else begin
            rsp_r.valid <= cmd.rdEn;
            rsp_r.data  <= cmd.rdEn ? readData : rsp_r.data;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rsp               = rsp_r;
    assign driveStrengthCode = drive_r;
    assign calReq            = cal_r;
    assign testMode          = testMode_r;
    // R8 hot indication
    assign overTemp   = rate[HOT_BIT];
    // R4 derate code
    assign derate     = (rate == RATE_QTR_DERATE);
    // R10 limits flagged for controller
    assign outOfRange = (rate == RATE_LOW_LIMIT) ||
                        (rate == RATE_HIGH_LIMIT);

endmodule

//--- verilog/temp_flag_tracker.sv
// Refresh-rate report synchroniser and change-flag tracker
`timescale 1ns/100ps
module temp_flag_tracker (
    input  wire logic       ref_clk,      // Command clock
    input  wire logic       srst,         // Synchronous reset, high
    input  wire logic [2:0] rateIn,       // Raw sensor rate, async
    input  wire logic       flagClear,    // Read of temperature reg
    output logic      [2:0] rate,         // Filtered rate report
    output logic            updateFlag    // Sticky change flag
);
    import mode_regs_pkg::*;

    // ------------------------------------------------------------
    // Three-stage synchroniser
    // ------------------------------------------------------------
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] rate_r;
    logic       flag_r;
    logic       stable;
    logic       changed;
    logic       flag_nxt;

    assign stable  = (sync2_r == sync3_r);
    assign changed = stable && (sync3_r != rate_r);

    // R5 clear on read
    // R7 set wins over clear
    assign flag_nxt = changed ? 1'b1 : (flagClear ? 1'b0 : flag_r);

    always_ff @(posedge ref_clk) begin
        sync1_r <= rateIn;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    // R6 flag zero at reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rate_r <= RATE_X1;
            flag_r <= 1'b0;
        end else begin
            if (changed) begin
                rate_r <= sync3_r;
            end
            flag_r <= flag_nxt;
        end
    end

    assign rate       = rate_r;
    assign updateFlag = flag_r;

endmodule
